// ### src/pmc_pkg.sv
// package for the power mode controller: register map, fields, timing
package pmc_pkg;

  // ******************************
  // register byte offsets
  // ******************************
  localparam logic [7:0] ADDR_MODE_REQ  = 8'h00; // mode request (write starts entry)
  localparam logic [7:0] ADDR_ACT_TMPL  = 8'h04; // active configuration template
  localparam logic [7:0] ADDR_ALT_TMPL  = 8'h08; // alternate active template
  localparam logic [7:0] ADDR_STATUS    = 8'h0c; // current mode and flags
  localparam logic [7:0] ADDR_REG_CTRL  = 8'h10; // core regulator enables
  localparam logic [7:0] ADDR_WAKE_MASK = 8'h14; // sleep wakeup source enables

  // ******************************
  // fields and encodings
  // ******************************
  localparam int          NUM_SUBSYS   = 8;      // power controllable subsystems
  localparam int          CPU_BIT      = 0;      // template bit of the cpu
  localparam int          FLASH_BIT    = 1;      // template bit of the flash
  localparam int          NUM_WAKE     = 6;      // sleep wakeup sources
  localparam int          PIN_WAKE_BIT = 1;      // pin_interrupt_unit source index
  localparam logic [1:0]  REQ_ACTIVE   = 2'h0;
  localparam logic [1:0]  REQ_ALT      = 2'h1;
  localparam logic [1:0]  REQ_SLEEP    = 2'h2;
  localparam logic [1:0]  REQ_HIB      = 2'h3;
  localparam logic [7:0]  ACT_TMPL_RST = 8'hff;  // all subsystems on after boot
  localparam logic [7:0]  ALT_TMPL_RST = 8'hfc;  // cpu and flash off, peripherals on
  localparam logic [7:0]  SLEEP_KEEP   = 8'h00;  // subsystems kept in sleep
  localparam logic [1:0]  REG_CTRL_RST = 2'h3;   // both core regulators on at power up
  localparam logic [5:0]  WAKE_RST     = 6'h3f;  // all sleep sources enabled

  // ******************************
  // timing
  // ******************************
  localparam int CLK_MHZ        = 10;
  localparam int SLEEP_RES_NS   = 15000;   // sleep resume interval
  localparam int HIB_RES_NS     = 100000;  // hibernate resume limit
  localparam int SLEEP_RES_CYC  = (SLEEP_RES_NS * CLK_MHZ + 999) / 1000;
  localparam int HIB_RES_CYC    = (HIB_RES_NS * CLK_MHZ) / 1000;
  localparam int CNT_W          = 11;

  typedef enum logic [2:0] {
    ST_ACTIVE, ST_ALT, ST_SLEEP, ST_HIB, ST_RESUME
  } pmc_state_t;

endpackage

// ### src/pmc_top.sv
// power mode controller with an AHB-Lite register slave
//
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pmc_top
  import pmc_pkg::*;
#(
  parameter int SLEEP_CYC = SLEEP_RES_CYC,
  parameter int HIB_CYC   = HIB_RES_CYC
) (
  input  wire logic              i_sys_clk,     // system clock, 10 MHz
  input  wire logic              i_nrst,        // synchronous reset, active low
  input  wire logic              i_hsel,        // ahb slave select
  input  wire logic [31:0]       i_haddr,       // ahb address
  input  wire logic [1:0]        i_htrans,      // ahb transfer type
  input  wire logic              i_hwrite,      // ahb write
  input  wire logic [2:0]        i_hsize,       // ahb size
  input  wire logic [31:0]       i_hwdata,      // ahb write data
  input  wire logic              i_hready,      // ahb ready in
  output logic [31:0]            o_hrdata,      // ahb read data
  output logic                   o_hreadyout,   // ahb ready out
  output logic                   o_hresp,       // ahb response, always okay
  input  wire logic [NUM_WAKE-1:0] i_wake_src,  // comparator,pin,i2c,rtc,timewheel,lvd
  input  wire logic              i_io_supply_ok, // all io supplies valid
  output logic [NUM_SUBSYS-1:0]  o_subsys_en,   // subsystem enables
  output logic [NUM_SUBSYS-1:0]  o_clk_gate,    // subsystem clock gate, high gates
  output logic [NUM_SUBSYS-1:0]  o_bias_cut,    // subsystem bias/leakage cut
  output logic                   o_low_osc_en,  // low_speed_internal_osc and watch_crystal_osc
  output logic                   o_core_reg_en, // core_digital_supply regulator
  output logic                   o_ana_reg_en,  // core_analog_supply regulator
  output logic                   o_all_clk_stop, // hibernate clock stop
  output logic [2:0]             o_mode         // current mode code
);

  // ******************************
  // registers
  // ******************************
  pmc_state_t              state_r;
  logic [NUM_SUBSYS-1:0]   act_tmpl_r;
  logic [NUM_SUBSYS-1:0]   alt_tmpl_r;
  logic [1:0]              reg_ctrl_r;
  logic [NUM_WAKE-1:0]     wake_mask_r;
  logic                    cpu_force_r;
  logic                    req_err_r;
  logic [CNT_W-1:0]        cnt_r;
  logic                    dph_wr_r;
  logic                    dph_rd_r;
  logic [7:0]              dph_addr_r;
  logic [NUM_SUBSYS-1:0]   en_nxt;

  logic       addr_ok;
  logic       wr_mode;
  logic       wake_any;
  logic [1:0] req;

  // decode a word offset; only the mapped words are accepted
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
    is_reg = (a == off);
  endfunction

  // ******************************
  // bus slave
  // ******************************
  assign addr_ok     = i_hsel && i_hready && i_htrans[1];
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  // capture address phase
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      dph_wr_r   <= 1'b0;
      dph_rd_r   <= 1'b0;
      dph_addr_r <= 8'h00;
    end else begin
      dph_wr_r   <= addr_ok && i_hwrite;
      dph_rd_r   <= addr_ok && !i_hwrite;
      dph_addr_r <= i_haddr[7:0];
    end
  end

  // read data registered at the address phase so it stands in the data phase
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_hrdata <= 32'h0000_0000;
    end else if (addr_ok && !i_hwrite) begin
      case (i_haddr[7:0])
        ADDR_ACT_TMPL:  o_hrdata <= {24'h00_0000, act_tmpl_r};
        ADDR_ALT_TMPL:  o_hrdata <= {24'h00_0000, alt_tmpl_r};
        ADDR_STATUS:    o_hrdata <= {27'h000_0000, req_err_r, cpu_force_r, o_mode};
        ADDR_REG_CTRL:  o_hrdata <= {30'h0000_0000, reg_ctrl_r};
        ADDR_WAKE_MASK: o_hrdata <= {26'h000_0000, wake_mask_r};
        default:        o_hrdata <= 32'h0000_0000;
      endcase
    end
  end

  assign wr_mode = dph_wr_r && is_reg(dph_addr_r, ADDR_MODE_REQ);
  assign req     = i_hwdata[1:0];

  // template writes take effect the next cycle
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      act_tmpl_r  <= ACT_TMPL_RST;
      alt_tmpl_r  <= ALT_TMPL_RST;
      reg_ctrl_r  <= REG_CTRL_RST; // regulators on after power up
      wake_mask_r <= WAKE_RST;
    end else if (dph_wr_r) begin
      if (is_reg(dph_addr_r, ADDR_ACT_TMPL))  act_tmpl_r  <= i_hwdata[NUM_SUBSYS-1:0];
      if (is_reg(dph_addr_r, ADDR_ALT_TMPL))  alt_tmpl_r  <= i_hwdata[NUM_SUBSYS-1:0];
      if (is_reg(dph_addr_r, ADDR_REG_CTRL))  reg_ctrl_r  <= i_hwdata[1:0];
      if (is_reg(dph_addr_r, ADDR_WAKE_MASK)) wake_mask_r <= i_hwdata[NUM_WAKE-1:0];
    end
  end

  // ******************************
  // mode state machine
  // ******************************
  // sleep wakes on enabled sources, hibernate only on the pin unit
  assign wake_any = (state_r == ST_HIB) ? i_wake_src[PIN_WAKE_BIT]
                                        : |(i_wake_src & wake_mask_r);

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      state_r <= ST_ACTIVE; // boot default
      cnt_r   <= '0;
    end else begin
      case (state_r)
        ST_ACTIVE, ST_ALT: begin
          // low modes only on a register write
          if (wr_mode) begin
            case (req)
              REQ_ALT:   state_r <= ST_ALT;
              REQ_SLEEP: state_r <= i_io_supply_ok ? ST_SLEEP : state_r;
              REQ_HIB:   state_r <= i_io_supply_ok ? ST_HIB : state_r;
              default:   state_r <= ST_ACTIVE;
            endcase
          end
        end
        ST_SLEEP: begin
          if (wake_any) begin
            state_r <= ST_RESUME; // settle before active
            cnt_r   <= CNT_W'(SLEEP_CYC - 1);
          end
        end
        ST_HIB: begin
          if (wake_any) begin
            state_r <= ST_RESUME; // resume well inside the limit
            cnt_r   <= CNT_W'(SLEEP_CYC - 1);
          end
        end
        ST_RESUME: begin
          if (cnt_r == '0) state_r <= ST_ACTIVE;
          else cnt_r <= cnt_r - 1'b1;
        end
        default: state_r <= ST_ACTIVE;
      endcase
    end
  end

  // wakeup re-enables the cpu until firmware writes the active template or the mode request
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      cpu_force_r <= 1'b0;
    end else if ((state_r == ST_RESUME) && (cnt_r == '0)) begin
      cpu_force_r <= 1'b1;
    end else if (dph_wr_r && (is_reg(dph_addr_r, ADDR_ACT_TMPL) || wr_mode)) begin
      cpu_force_r <= 1'b0;
    end
  end

  // refused low-power request flag: set wins over clear by status read
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      req_err_r <= 1'b0;
    end else if (wr_mode && req[1] && !i_io_supply_ok) begin
      req_err_r <= 1'b1;
    end else if (dph_rd_r && is_reg(dph_addr_r, ADDR_STATUS)) begin
      req_err_r <= 1'b0;
    end
  end

  // ******************************
  // subsystem controls
  // ******************************
  always_comb begin
    case (state_r)
      ST_ACTIVE: en_nxt = act_tmpl_r;
      ST_ALT:    en_nxt = alt_tmpl_r;
      ST_SLEEP:  en_nxt = SLEEP_KEEP;
      default:   en_nxt = '0;
    endcase
    if (cpu_force_r && (state_r == ST_ACTIVE)) en_nxt[CPU_BIT] = 1'b1;
  end

  // registered controls; disabled gets gate and cut
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_subsys_en    <= ACT_TMPL_RST;
      o_clk_gate     <= '0;
      o_bias_cut     <= '0;
      o_low_osc_en   <= 1'b1;
      o_all_clk_stop <= 1'b0;
      o_mode         <= 3'(ST_ACTIVE);
    end else begin
      o_subsys_en    <= en_nxt;
      o_clk_gate     <= ~en_nxt;
      o_bias_cut     <= ~en_nxt;
      o_low_osc_en   <= (state_r != ST_HIB);   // kept in sleep
      o_all_clk_stop <= (state_r == ST_HIB);
      o_mode         <= 3'(state_r);
    end
  end

  assign o_core_reg_en = reg_ctrl_r[0];
  assign o_ana_reg_en  = reg_ctrl_r[1];

  // ******************************
  // assertions
  // ******************************
  sequence s_sleep_wake;
    (state_r == ST_SLEEP) && wake_any;
  endsequence

  // hibernate wake, seen only on the pin unit
  sequence s_hib_wake;
    (state_r == ST_HIB) && wake_any;
  endsequence

  // resume window bounds follow the resume count parameter
  localparam int RES_LO = SLEEP_CYC;
  localparam int RES_HI = SLEEP_CYC + 1;

  a_reset_active: assert property (@(posedge i_sys_clk) !i_nrst |=> state_r == ST_ACTIVE)
    else $error("not active after reset");
  a_gate_follows: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    o_clk_gate == ~o_subsys_en) else $error("gate and enable disagree");
  a_active_tmpl: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (state_r == ST_ACTIVE && !cpu_force_r) |=> o_subsys_en == $past(act_tmpl_r))
    else $error("active enables differ from template");
  a_sleep_off: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    state_r == ST_SLEEP |=> o_subsys_en == SLEEP_KEEP && o_low_osc_en)
    else $error("sleep left subsystems on");
  a_resume_wait: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    s_sleep_wake |=> (state_r == ST_RESUME)[*8]) else $error("resume too short");
  a_resume_end: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    s_sleep_wake |-> ##[RES_LO:RES_HI] state_r == ST_ACTIVE) else $error("no return to active");
  a_hib_pin: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (state_r == ST_HIB && !i_wake_src[PIN_WAKE_BIT]) |=> state_r == ST_HIB)
    else $error("hibernate left without pin");
  a_cpu_wake: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (state_r == ST_RESUME && cnt_r == '0) |=> ##1 o_subsys_en[CPU_BIT])
    else $error("cpu not enabled on wakeup");
  a_entry_write: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (state_r == ST_ACTIVE && !wr_mode) |=> state_r == ST_ACTIVE)
    else $error("mode left without request");

  // alternate mode, template application, refusal and low mode checks
  a_alt_stay: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (state_r == ST_ALT && !wr_mode) |=> state_r == ST_ALT)
    else $error("alternate mode left without request");
  a_alt_tmpl: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    state_r == ST_ALT |=> o_subsys_en == $past(alt_tmpl_r))
    else $error("alternate enables differ from template");
  a_tmpl_apply: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (state_r == ST_ACTIVE && dph_wr_r && is_reg(dph_addr_r, ADDR_ACT_TMPL))
    |=> ##1 o_subsys_en == NUM_SUBSYS'($past(i_hwdata, 2)))
    else $error("template write not applied");
  a_refuse_low: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    ((state_r == ST_ACTIVE || state_r == ST_ALT) && wr_mode && req[1] && !i_io_supply_ok)
    |=> state_r == $past(state_r) && req_err_r)
    else $error("low mode entered with io supplies invalid");
  a_sleep_stay: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (state_r == ST_SLEEP && !wake_any) |=> state_r == ST_SLEEP)
    else $error("sleep left without enabled source");
  a_hib_stop: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    state_r == ST_HIB |=> o_all_clk_stop && !o_low_osc_en && o_subsys_en == '0)
    else $error("hibernate left clocks running");
  // hibernate resume must finish inside the hibernate limit
  a_hib_resume: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    s_hib_wake |-> ##[1:HIB_CYC] state_r == ST_ACTIVE)
    else $error("hibernate resume too slow");
  // core regulators must come up enabled
  a_reg_reset: assert property (@(posedge i_sys_clk)
    !i_nrst |=> o_core_reg_en && o_ana_reg_en) else $error("regulators off after reset");

endmodule
`default_nettype wire

// ### testbench/test_power_mode_controller.sv
// self-checking testbench for the power mode controller
`timescale 1ns/1ps
`default_nettype none
module test_power_mode_controller import pmc_pkg::*; ;
  // ******************************
  // stimulus and observed signals
  // ******************************
  localparam int   SC = SLEEP_RES_CYC;   // full resume count
  logic            clk = 1'b0;
  logic            nrst = 1'b0;
  logic            hsel = 1'b0;
  logic            hwrite = 1'b0;
  logic            supok = 1'b0;
  logic [1:0]      htrans = 2'h0;
  logic [31:0]     haddr = 32'h0;
  logic [31:0]     hwdata = 32'h0;
  logic [5:0]      wake = 6'h00;
  logic [31:0]     hrdata;
  logic [31:0]     junk;
  logic            rdy, resp, losc, creg, areg, stop;
  logic [7:0]      en, gate, bias;
  logic [2:0]      mode;
  int              failures = 0;
  int              compares = 0;
  int              cyc = 0;

  pmc_top #(.SLEEP_CYC(SC)) DUT (
    .i_sys_clk(clk), .i_nrst(nrst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(rdy), .o_hrdata(hrdata),
    .o_hreadyout(rdy), .o_hresp(resp), .i_wake_src(wake), .i_io_supply_ok(supok),
    .o_subsys_en(en), .o_clk_gate(gate), .o_bias_cut(bias), .o_low_osc_en(losc),
    .o_core_reg_en(creg), .o_ana_reg_en(areg), .o_all_clk_stop(stop), .o_mode(mode));

  // clock and hang guard
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      report_and_stop();
    end
  end

  // ******************************
  // shared tasks
  // ******************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one ahb single transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic wait_mode(input logic [2:0] m);
    int n;
    n = 0;
    while (mode !== m && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("o_mode", {29'h0, m}, {29'h0, mode});
  endtask

  // ******************************
  // scenarios
  // ******************************
  task automatic t_reset();
    chk("mode", 32'h0, {29'h0, mode});
    chk("en", 32'hff, {24'h0, en});
    chk("gate", 32'h0, {24'h0, gate});
    chk("regs", 32'h7, {29'h0, losc, creg, areg});
    chk("hreadyout", 32'h1, {31'h0, rdy});
    chk("hresp", 32'h0, {31'h0, resp});
    bus(1'b0, ADDR_ACT_TMPL, 32'h0, junk);
    chk("act_tmpl", 32'hff, junk);
    bus(1'b0, ADDR_ALT_TMPL, 32'h0, junk);
    chk("alt_tmpl", 32'hfc, junk);
    bus(1'b0, ADDR_REG_CTRL, 32'h0, junk);
    chk("reg_ctrl", 32'h3, junk);
    bus(1'b0, 8'h18, 32'h0, junk);
    chk("unmapped", 32'h0, junk);
  endtask

  // cpu bit cleared by firmware, gates follow at once
  task automatic t_tmpl();
    bus(1'b1, ADDR_ACT_TMPL, 32'h5a, junk);
    repeat (2) @(posedge clk);
    chk("en", 32'h5a, {24'h0, en});
    chk("gate", 32'ha5, {24'h0, gate});
    chk("bias", 32'ha5, {24'h0, bias});
  endtask

  task automatic t_alt();
    bus(1'b1, ADDR_MODE_REQ, 32'h1, junk);
    wait_mode(3'h1);
    repeat (2) @(posedge clk);
    chk("alt en", 32'hfc, {24'h0, en});
    bus(1'b1, ADDR_MODE_REQ, 32'h0, junk);
    wait_mode(3'h0);
    repeat (2) @(posedge clk);
    chk("act en", 32'h5a, {24'h0, en});
  endtask

  // refused entry, then sleep, wake and timed resume
  task automatic t_sleep();
    int n;
    bus(1'b1, ADDR_MODE_REQ, 32'h2, junk);
    repeat (3) @(posedge clk);
    chk("refused", 32'h0, {29'h0, mode});
    bus(1'b0, ADDR_STATUS, 32'h0, junk);
    chk("err", 32'h1, {31'h0, junk[4]});
    supok <= 1'b1;
    bus(1'b1, ADDR_MODE_REQ, 32'h2, junk);
    wait_mode(3'h2);
    repeat (2) @(posedge clk);
    chk("sleep en", 32'h0, {24'h0, en});
    chk("low osc", 32'h1, {31'h0, losc});
    wake <= 6'h01;
    wait_mode(3'h4);
    wake <= 6'h00;
    n = 0;
    while (mode !== 3'h0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("resume", 32'h1, {31'h0, (n >= SC - 1 && n <= SC + 1)});
    repeat (3) @(posedge clk);
    chk("cpu on", 32'h1, {31'h0, en[0]});
  endtask

  task automatic t_hib();
    bus(1'b1, ADDR_MODE_REQ, 32'h3, junk);
    wait_mode(3'h3);
    repeat (2) @(posedge clk);
    chk("stop", 32'h2, {30'h0, stop, losc});
    wake <= 6'h01;
    repeat (10) @(posedge clk);
    chk("no wake", 32'h3, {29'h0, mode});
    wake <= 6'h02;
    wait_mode(3'h4);
    wake <= 6'h00;
    wait_mode(3'h0);
  endtask

  task automatic t_reg();
    bus(1'b1, ADDR_REG_CTRL, 32'h0, junk);
    repeat (2) @(posedge clk);
    chk("reg off", 32'h0, {30'h0, creg, areg});
  endtask

  // ******************************
  // main sequence and verdict
  // ******************************
  task automatic report_and_stop();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_tmpl();
    t_alt();
    t_sleep();
    t_hib();
    t_reg();
    report_and_stop();
  end
endmodule
`default_nettype wire
